// ===== core/pmc_consts.svh
// Constant definitions for the power mode and peripheral clock control block
// Summary of operation
// - Idle halts processor until reset or interrupt
// - Peripherals run in Idle; interrupts end it
// - Idle gates processor, memory, bus clocks
// - Power-down stops oscillator and all clocks but a 32 kHz RTC
// - Power-down retains state, holds output pins
// - Power-down ends only on reset or wake
// - Nine external inputs, edge or level each
// - External inputs combine into four interrupt requests
// - Each external input may enable wake-up
// - Capture inputs interrupt but never wake
// - RTC on 32 kHz keeps counting in Power-down
// - Software gates each peripheral clock individually
// - Peripheral clock is full, half, quarter rate
// - Divider resets to quarter rate
// - Running PLL stays running during Idle
// - Power-down exit waits for wake-up timer
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
// Register byte offsets
`define PMC_OFS_MODE      8'h00
`define PMC_OFS_PERIPH    8'h04
`define PMC_OFS_DIV       8'h08
`define PMC_OFS_EDGE      8'h0C
`define PMC_OFS_WAKE      8'h10
`define PMC_OFS_STATUS    8'h14
`define PMC_OFS_MASK      8'h18
`define PMC_OFS_CFG       8'h1C
// Field positions
`define PMC_MODE_IDLE     0
`define PMC_MODE_PDOWN    1
`define PMC_CFG_RTC32K    0
// Widths
`define PMC_NEXT          9
`define PMC_NCAP          4
`define PMC_NSTAT         13
`define PMC_NPERIPH       16
`define PMC_NGRP          4
// Reset values and divider codes
`define PMC_RST_PERIPH    16'hFFFF
`define PMC_DIV_QUARTER   2'h0
`define PMC_DIV_FULL      2'h1
`define PMC_DIV_HALF      2'h2
// Wake-up timer
`define PMC_CLK_PERIOD_NS 25
`define PMC_WAKE_TIME_NS  2000
`define PMC_WAKE_CYCLES   ((`PMC_WAKE_TIME_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_WAKE_W        8
`endif

// ===== core/pmc_pkg.sv
// Types shared by the power mode and peripheral clock control block
package pmc_pkg;
    // Power mode states
    typedef enum logic [1:0] {
        PMC_RUN,
        PMC_IDLE,
        PMC_PDOWN,
        PMC_WAKE
    } pmc_state_t;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pmc_apb_req_t;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } pmc_apb_rsp_t;

    // Clock gate enables toward the chip
    typedef struct packed {
        logic cpu;
        logic mem;
        logic bus;
        logic osc;
        logic pclk;
        logic rtc;
        logic pll;
    } pmc_clk_en_t;
endpackage

// ===== core/pmc_top.sv
// Power mode, wake-up, external interrupt and peripheral clock control
`timescale 1ns/100ps
`include "pmc_consts.svh"
module pmc_top
    import pmc_pkg::*;
(
    input  wire logic                      MCLK,
    input  wire logic                      RESETN,
    input  wire pmc_apb_req_t              APB_IN,
    output pmc_apb_rsp_t                   APB_OUT,
    input  wire logic [`PMC_NEXT-1:0]      EXT_PIN,
    input  wire logic [`PMC_NCAP-1:0]      CAP_PIN,
    input  wire logic                      PERIPH_IRQ,
    input  wire logic                      PLL_REQ,
    output pmc_clk_en_t                    CLK_EN,
    output logic [`PMC_NPERIPH-1:0]        PERIPH_EN,
    output logic [`PMC_NGRP-1:0]           EINT_REQ,
    output logic                           IRQ,
    output logic                           PIN_HOLD,
    output pmc_state_t                     MODE
);

    // Software visible registers
    logic [`PMC_NPERIPH-1:0] periph;      // Per-peripheral enables
    logic [1:0]              div;         // Peripheral clock ratio
    logic [`PMC_NEXT-1:0]    edge_sel;    // One selects edge, zero level
    logic [`PMC_NEXT-1:0]    wake_en;     // Wake-up enables
    logic [`PMC_NSTAT-1:0]   status;      // Sticky event bits
    logic [`PMC_NSTAT-1:0]   mask;        // Interrupt mask
    logic                    rtc32k;      // RTC runs from 32 kHz source

    // Internal state
    pmc_state_t              state;       // Current power mode
    pmc_state_t              next_state;  // Mode for the next cycle
    logic [`PMC_NEXT-1:0]    ext_prev;    // Pin levels one cycle ago
    logic [`PMC_NCAP-1:0]    cap_prev;    // Capture levels one cycle ago
    logic [1:0]              div_cnt;     // Divider phase
    logic [`PMC_WAKE_W-1:0]  wake_cnt;    // Wake-up timer count
    logic [`PMC_NSTAT-1:0]   set_ev;      // Events seen this cycle
    logic [`PMC_NGRP-1:0]    next_grp;    // Combined group requests
    logic                    pclk_tick;   // Divider strobe this cycle
    logic                    wr;          // Write taken this cycle
    logic                    sel_mode;    // Mode register addressed
    logic                    any_irq;     // Unmasked event or peripheral irq
    logic                    wake_hit;    // Wake-capable event in Power-down

    // Write strobe: the edge where the access phase meets pready
    assign wr       = APB_IN.psel & APB_IN.penable & APB_IN.pwrite & APB_OUT.pready;
    assign sel_mode = (APB_IN.paddr == `PMC_OFS_MODE);

    // Event detection for external and capture inputs
    always_comb
    begin
        set_ev = '0;
        // Edge or level detection per external pin
        for (int i = 0; i < `PMC_NEXT; i++)
        begin
            set_ev[i] = edge_sel[i] ? (EXT_PIN[i] & ~ext_prev[i]) : EXT_PIN[i];
        end
        // Capture inputs need the clock, so nothing in Power-down
        for (int j = 0; j < `PMC_NCAP; j++)
        begin
            set_ev[`PMC_NEXT+j] = CAP_PIN[j] & ~cap_prev[j]
                                  & (state != PMC_PDOWN);
        end
    end

    // External pins are combined onto four request lines, pin i to group i mod 4
    always_comb
    begin
        next_grp = '0;
        for (int k = 0; k < `PMC_NEXT; k++)
        begin
            next_grp[k % `PMC_NGRP] = next_grp[k % `PMC_NGRP]
                                      | (status[k] & mask[k]);
        end
    end

    // Wake sources: only external pins with their enable set
    assign wake_hit = |(set_ev[`PMC_NEXT-1:0] & wake_en);
    assign any_irq  = (|(status & mask)) | PERIPH_IRQ;

    // Power mode sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            PMC_RUN:
            begin
                // Mode write takes effect on the next edge
                if (wr && sel_mode && APB_IN.pwdata[`PMC_MODE_PDOWN])
                begin
                    next_state = PMC_PDOWN;
                end
                else if (wr && sel_mode && APB_IN.pwdata[`PMC_MODE_IDLE])
                begin
                    next_state = PMC_IDLE;
                end
            end
            PMC_IDLE:
            begin
                // Any interrupt resumes execution
                if (any_irq)
                begin
                    next_state = PMC_RUN;
                end
            end
            PMC_PDOWN:
            begin
                // Only a wake-capable event leaves Power-down
                if (wake_hit)
                begin
                    next_state = PMC_WAKE;
                end
            end
            PMC_WAKE:
            begin
                // Processor held until the oscillator settles
                if (wake_cnt == `PMC_WAKE_W'(`PMC_WAKE_CYCLES - 1))
                begin
                    next_state = PMC_RUN;
                end
            end
            default:
            begin
                next_state = PMC_RUN;
            end
        endcase
    end

    // Mode register; reset always returns to run
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state <= PMC_RUN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Wake-up timer counts only while waking
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wake_cnt <= '0;
        end
        else if (state == PMC_WAKE)
        begin
            wake_cnt <= wake_cnt + `PMC_WAKE_W'(1);
        end
        else
        begin
            wake_cnt <= '0;
        end
    end

    // Previous input levels for edge detection
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ext_prev <= '0;
            cap_prev <= '0;
        end
        else
        begin
            ext_prev <= EXT_PIN;
            cap_prev <= CAP_PIN;
        end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            status <= '0;
        end
        else if (wr && APB_IN.paddr == `PMC_OFS_STATUS)
        begin
            status <= (status & ~APB_IN.pwdata[`PMC_NSTAT-1:0]) | set_ev;
        end
        else
        begin
            status <= status | set_ev;
        end
    end

    // Software writable configuration; kept through Power-down
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            periph   <= `PMC_RST_PERIPH;
            div      <= `PMC_DIV_QUARTER;
            edge_sel <= '0;
            wake_en  <= '0;
            mask     <= '0;
            rtc32k   <= 1'b0;
        end
        else if (wr)
        begin
            // Address decode for configuration writes
            if (APB_IN.paddr == `PMC_OFS_PERIPH)
            begin
                periph <= APB_IN.pwdata[`PMC_NPERIPH-1:0];
            end
            else if (APB_IN.paddr == `PMC_OFS_DIV)
            begin
                div <= APB_IN.pwdata[1:0];
            end
            else if (APB_IN.paddr == `PMC_OFS_EDGE)
            begin
                edge_sel <= APB_IN.pwdata[`PMC_NEXT-1:0];
            end
            else if (APB_IN.paddr == `PMC_OFS_WAKE)
            begin
                wake_en <= APB_IN.pwdata[`PMC_NEXT-1:0];
            end
            else if (APB_IN.paddr == `PMC_OFS_MASK)
            begin
                mask <= APB_IN.pwdata[`PMC_NSTAT-1:0];
            end
            else if (APB_IN.paddr == `PMC_OFS_CFG)
            begin
                rtc32k <= APB_IN.pwdata[`PMC_CFG_RTC32K];
            end
        end
    end

    // Peripheral clock divider, stopped in Power-down and wake-up
    // Phase follows the next mode, so the strobe is not doubled on leaving wake-up
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            div_cnt <= '0;
        end
        else if (next_state == PMC_RUN || next_state == PMC_IDLE)
        begin
            div_cnt <= div_cnt + 2'h1;
        end
        else
        begin
            div_cnt <= '0;
        end
    end

    // Strobe at full, half or quarter rate
    always_comb
    begin
        if (div == `PMC_DIV_FULL)
        begin
            pclk_tick = 1'b1;
        end
        else if (div == `PMC_DIV_HALF)
        begin
            pclk_tick = (div_cnt[0] == 1'b0);
        end
        else
        begin
            pclk_tick = (div_cnt == 2'h0);
        end
    end

    // Clock gates per mode
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            CLK_EN    <= '0;
            PERIPH_EN <= '0;
            PIN_HOLD  <= 1'b0;
        end
        else
        begin
            // Processor, memory and bus only in run
            CLK_EN.cpu <= (next_state == PMC_RUN);
            CLK_EN.mem <= (next_state == PMC_RUN);
            CLK_EN.bus <= (next_state == PMC_RUN);
            // Oscillator off only in Power-down
            CLK_EN.osc <= (next_state != PMC_PDOWN);
            // Peripheral strobe keeps running in Idle
            CLK_EN.pclk <= pclk_tick
                           & (next_state == PMC_RUN || next_state == PMC_IDLE);
            // PLL follows its request except in Power-down and wake-up
            CLK_EN.pll <= PLL_REQ & (next_state == PMC_RUN || next_state == PMC_IDLE);
            // RTC on 32 kHz source runs in every mode
            CLK_EN.rtc <= rtc32k | (pclk_tick
                           & (next_state == PMC_RUN || next_state == PMC_IDLE));
            // Individual peripheral gating in run and Idle
            PERIPH_EN <= periph
                         & {`PMC_NPERIPH{next_state == PMC_RUN || next_state == PMC_IDLE}};
            // Output pins frozen until the processor resumes
            PIN_HOLD <= (next_state == PMC_PDOWN || next_state == PMC_WAKE);
        end
    end

    // Interrupt and mode outputs
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            EINT_REQ <= '0;
            IRQ      <= 1'b0;
            MODE     <= PMC_RUN;
        end
        else
        begin
            EINT_REQ <= next_grp;
            IRQ      <= |(status & mask);
            MODE     <= state;
        end
    end

    // APB answer: ready one cycle after setup, read data captured then
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            APB_OUT <= '0;
        end
        else if (APB_IN.psel && !APB_IN.penable)
        begin
            APB_OUT.pready  <= 1'b1;
            APB_OUT.pslverr <= 1'b0;
            APB_OUT.prdata  <= '0;
            // Read decode
            if (APB_IN.paddr == `PMC_OFS_MODE)
            begin
                APB_OUT.prdata[`PMC_MODE_IDLE]  <= (state == PMC_IDLE);
                APB_OUT.prdata[`PMC_MODE_PDOWN] <= (state == PMC_PDOWN);
            end
            else if (APB_IN.paddr == `PMC_OFS_PERIPH)
            begin
                APB_OUT.prdata[`PMC_NPERIPH-1:0] <= periph;
            end
            else if (APB_IN.paddr == `PMC_OFS_DIV)
            begin
                APB_OUT.prdata[1:0] <= div;
            end
            else if (APB_IN.paddr == `PMC_OFS_EDGE)
            begin
                APB_OUT.prdata[`PMC_NEXT-1:0] <= edge_sel;
            end
            else if (APB_IN.paddr == `PMC_OFS_WAKE)
            begin
                APB_OUT.prdata[`PMC_NEXT-1:0] <= wake_en;
            end
            else if (APB_IN.paddr == `PMC_OFS_STATUS)
            begin
                APB_OUT.prdata[`PMC_NSTAT-1:0] <= status;
            end
            else if (APB_IN.paddr == `PMC_OFS_MASK)
            begin
                APB_OUT.prdata[`PMC_NSTAT-1:0] <= mask;
            end
            else if (APB_IN.paddr == `PMC_OFS_CFG)
            begin
                APB_OUT.prdata[`PMC_CFG_RTC32K] <= rtc32k;
            end
            else
            begin
                // Unmapped: error, data zero
                APB_OUT.pslverr <= 1'b1;
            end
        end
        else
        begin
            // Access phase done or idle bus
            APB_OUT.pready  <= 1'b0;
            APB_OUT.pslverr <= 1'b0;
        end
    end

endmodule

// ===== tb/pmc_checker.sv
// Port checker for the power mode and peripheral clock control block
`timescale 1ns/100ps
`include "pmc_consts.svh"
module pmc_checker
    import pmc_pkg::*;
(
    input wire logic                     MCLK,
    input wire logic                     RESETN,
    input wire pmc_apb_req_t             APB_IN,
    input wire pmc_apb_rsp_t             APB_OUT,
    input wire logic [`PMC_NEXT-1:0]     EXT_PIN,
    input wire logic                     PERIPH_IRQ,
    input wire logic                     PLL_REQ,
    input wire pmc_clk_en_t              CLK_EN,
    input wire logic [`PMC_NPERIPH-1:0]  PERIPH_EN,
    input wire logic [`PMC_NGRP-1:0]     EINT_REQ,
    input wire logic                     IRQ,
    input wire logic                     PIN_HOLD
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    logic [7:0] wake_cnt;  // Cycles spent in wake-up
    logic [2:0] gap;       // Cycles since the last peripheral strobe
    logic       gap_ok;    // Gap is counted from a real strobe
    logic       wr_div_q;  // Divider write one cycle ago
    logic [1:0] div;       // Divider code seen on the bus
    logic       wr_div;    // Completed divider write
    logic       in_idle;   // Clocks up, processor stopped
    logic       in_pdown;  // Oscillator off, pins held
    logic       run_idle;  // Run or idle

    assign run_idle = CLK_EN.osc && !PIN_HOLD;
    assign in_idle  = run_idle && !CLK_EN.cpu;
    assign in_pdown = PIN_HOLD && !CLK_EN.osc;
    assign wr_div   = APB_IN.psel && APB_IN.penable && APB_OUT.pready && APB_IN.pwrite
                      && APB_IN.paddr == `PMC_OFS_DIV;

    // Track divider code and wake-up length
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            div      <= `PMC_DIV_QUARTER;
            wake_cnt <= 8'h00;
        end
        else
        begin
            if (wr_div)
                div <= APB_IN.pwdata[1:0];
            wake_cnt <= (CLK_EN.osc && PIN_HOLD) ? wake_cnt + 8'h01 : 8'h00;
        end
    end

    // Strobe spacing; restarts on mode stops and for two cycles after a divider
    // write, since the strobe launched at the write edge still follows the old ratio
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            gap      <= 3'h0;
            gap_ok   <= 1'b0;
            wr_div_q <= 1'b0;
        end
        else
        begin
            wr_div_q <= wr_div;
            if (!run_idle || wr_div || wr_div_q)
            begin
                gap    <= 3'h0;
                gap_ok <= 1'b0;
            end
            else if (CLK_EN.pclk)
            begin
                gap    <= 3'h1;
                gap_ok <= 1'b1;
            end
            else if (gap != 3'h7)
            begin
                gap <= gap + 3'h1;
            end
        end
    end

    sequence s_setup;
        APB_IN.psel && !APB_IN.penable;
    endsequence
    sequence s_answer;
        APB_OUT.pready ##1 !APB_OUT.pready;
    endsequence

    a_apb_one_wait: assert property (s_setup |=> s_answer)
        else $error("APB answer not one cycle after setup");
    a_addr_decode: assert property (s_setup |=> APB_OUT.pslverr
        == ($past(APB_IN.paddr) > 8'h1C || $past(APB_IN.paddr[1:0]) != 2'h0))
        else $error("APB error flag does not match address");
    a_idle_gates: assert property (in_idle |-> !CLK_EN.mem && !CLK_EN.bus
        && CLK_EN.pll == $past(PLL_REQ)) else $error("Idle clock gating wrong");
    a_pdown_dark: assert property (in_pdown |-> !CLK_EN.cpu && !CLK_EN.mem
        && !CLK_EN.bus && !CLK_EN.pclk && PERIPH_EN == '0)
        else $error("Clock alive in power-down");
    a_pdown_no_wake: assert property (in_pdown && EXT_PIN == '0 |=> in_pdown)
        else $error("Power-down left without a pin event");
    a_wake_span: assert property ($rose(CLK_EN.cpu) && wake_cnt != 8'h00
        |-> wake_cnt == `PMC_WAKE_CYCLES) else $error("Wake-up timer length wrong");
    a_idle_wakes: assert property (in_idle && PERIPH_IRQ |-> ##[1:2] CLK_EN.cpu)
        else $error("Idle not ended by interrupt");
    a_idle_holds: assert property (in_idle && !PERIPH_IRQ && !$past(PERIPH_IRQ) && !IRQ
        |=> !CLK_EN.cpu || IRQ) else $error("Idle ended without cause");
    a_group_irq: assert property (|EINT_REQ |-> IRQ)
        else $error("Group request without interrupt");
    a_pclk_ratio: assert property (CLK_EN.pclk && gap_ok
        |-> gap == ((div == `PMC_DIV_FULL) ? 3'h1 : (div == `PMC_DIV_HALF) ? 3'h2 : 3'h4))
        else $error("Peripheral strobe spacing wrong");
    a_mode_enter: assert property ((s_setup and (APB_IN.pwrite
        && APB_IN.paddr == `PMC_OFS_MODE && APB_IN.pwdata[1:0] != 2'h0 && CLK_EN.cpu))
        |-> ##[1:2] !CLK_EN.cpu)
        else $error("Mode write did not stop the processor");
endmodule

bind pmc_top pmc_checker u_chk (.MCLK(MCLK), .RESETN(RESETN), .APB_IN(APB_IN), .APB_OUT(APB_OUT),
    .EXT_PIN(EXT_PIN), .PERIPH_IRQ(PERIPH_IRQ), .PLL_REQ(PLL_REQ), .CLK_EN(CLK_EN),
    .PERIPH_EN(PERIPH_EN), .EINT_REQ(EINT_REQ), .IRQ(IRQ), .PIN_HOLD(PIN_HOLD));

// ===== tb/pmc_core_model.sv
// Model of the processor core and peripherals beside the block
`timescale 1ns/100ps
module pmc_core_model
    import pmc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire pmc_clk_en_t clk_en,     // Clock gates from the block
    input  wire logic        raise,      // Peripheral event wanted
    output logic             periph_irq  // Interrupt toward the block
);
    // Peripheral flags only on its own strobe; the running core clears it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            periph_irq <= 1'b0;
        else if (raise && clk_en.pclk)
            periph_irq <= 1'b1;        // Event while clocked
        else if (clk_en.cpu)
            periph_irq <= 1'b0;        // Handler has run
    end
endmodule

// ===== tb/tb.sv
// Testbench for the power mode and peripheral clock control block
`timescale 1ns/100ps
`include "pmc_consts.svh"
module tb
    import pmc_pkg::*;
;
    logic         clk;         // Processor clock
    logic         rst_n;       // Reset, active low
    pmc_apb_req_t apb_in;      // Bus request
    pmc_apb_rsp_t apb_out;     // Bus answer
    logic [8:0]   ext_pin;     // External interrupt pins
    logic [3:0]   cap_pin;     // Capture pins
    logic         periph_irq;  // From peripheral model
    logic         pll_req;     // PLL wanted
    logic         raise;       // Ask model for an event
    pmc_clk_en_t  clk_en;      // Clock gates
    logic [15:0]  periph_en;   // Peripheral enables
    logic [3:0]   eint_req;    // Group requests
    logic         irq;         // Interrupt line
    logic         pin_hold;    // Pins frozen
    pmc_state_t   mode;        // Mode report
    logic [31:0]  rd;          // Last read data
    logic         err;         // Last error flag
    int           errors;      // Mismatch count
    int           compares;    // Comparison count
    logic [31:0]  rst_val [8] = '{32'h0, 32'h0000FFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    // Clock at 40 MHz
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    pmc_top dut (.MCLK(clk), .RESETN(rst_n), .APB_IN(apb_in), .APB_OUT(apb_out),
        .EXT_PIN(ext_pin), .CAP_PIN(cap_pin), .PERIPH_IRQ(periph_irq), .PLL_REQ(pll_req),
        .CLK_EN(clk_en), .PERIPH_EN(periph_en), .EINT_REQ(eint_req), .IRQ(irq),
        .PIN_HOLD(pin_hold), .MODE(mode));
    pmc_core_model u_core (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .raise(raise),
        .periph_irq(periph_irq));

    // Compare and count
    task cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    // One APB transfer: setup, then access until pready; only the watchdog ends a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        apb_in.penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (apb_out.pready !== 1'b1);
        rd = apb_out.prdata;
        err = apb_out.pslverr;
        apb_in.psel <= 1'b0;
        apb_in.penable <= 1'b0;
    endtask

    // Read and compare one register
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp($sformatf("register %h", a), exp, rd);
    endtask

    // Wait, bounded, for the processor clock
    task wait_cpu(input int limit);
        int n;
        n = 0;
        while (clk_en.cpu !== 1'b1 && n < limit)
        begin
            @(posedge clk);
            n++;
        end
        cmp("processor clock", 32'h1, clk_en.cpu);
    endtask

    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial
    begin
        #(25 * 20000);
        errors++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        errors = 0;
        compares = 0;
        rst_n = 1'b0;
        apb_in = '0;
        ext_pin = '0;
        cap_pin = '0;
        pll_req = 1'b0;
        raise = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then an unmapped place
        for (int i = 0; i < 8; i++)
            rdchk(8'(4 * i), rst_val[i]);
        apb(1'b0, 8'h20, 32'h0);
        cmp("unmapped error", 32'h1, err);
        cmp("unmapped data", 32'h0, rd);
        // Peripheral gating and divider codes 1 to 3
        apb(1'b1, `PMC_OFS_PERIPH, 32'h0000_00A5);
        repeat (2) @(posedge clk);
        cmp("periph_en", 32'h00A5, periph_en);
        for (int c = 1; c < 4; c++)
        begin
            apb(1'b1, `PMC_OFS_DIV, 32'(c));
            repeat (12) @(posedge clk);
            rdchk(`PMC_OFS_DIV, 32'(c));
        end
        // Each pin once: status, group request, interrupt, clear
        apb(1'b1, `PMC_OFS_MASK, 32'h1FFF);
        for (int k = 0; k < 13; k++)
        begin
            if (k < 9)
                ext_pin <= 9'(1 << k);
            else
                cap_pin <= 4'(1 << (k - 9));
            @(posedge clk);
            ext_pin <= '0;
            cap_pin <= '0;
            repeat (3) @(posedge clk);
            cmp("eint_req", k < 9 ? 32'(1 << (k % 4)) : 32'h0, eint_req);
            cmp("irq set", 32'h1, irq);
            rdchk(`PMC_OFS_STATUS, 32'(1 << k));
            apb(1'b1, `PMC_OFS_STATUS, 32'(1 << k));
            repeat (2) @(posedge clk);
            cmp("irq clear", 32'h0, irq);
        end
        // Edge mode: a held pin sets status only once
        apb(1'b1, `PMC_OFS_EDGE, 32'h1FF);
        ext_pin <= 9'h008;
        apb(1'b1, `PMC_OFS_STATUS, 32'h8);
        rdchk(`PMC_OFS_STATUS, 32'h0);
        ext_pin <= '0;
        apb(1'b1, `PMC_OFS_EDGE, 32'h0);
        // Idle: processor stopped, peripherals and PLL run, interrupt resumes
        pll_req <= 1'b1;
        apb(1'b1, `PMC_OFS_MODE, 32'h1);
        repeat (3) @(posedge clk);
        cmp("idle cpu", 32'h0, clk_en.cpu);
        cmp("idle pll", 32'h1, clk_en.pll);
        cmp("idle periph_en", 32'h00A5, periph_en);
        repeat (20) @(posedge clk);
        cmp("idle mode", 32'(PMC_IDLE), mode);
        raise <= 1'b1;
        wait_cpu(40);
        raise <= 1'b0;
        // Power-down: only a wake-enabled pin ends it, through the timer
        apb(1'b1, `PMC_OFS_CFG, 32'h1);
        apb(1'b1, `PMC_OFS_WAKE, 32'h010);
        apb(1'b1, `PMC_OFS_MASK, 32'h0);
        apb(1'b1, `PMC_OFS_MODE, 32'h2);
        repeat (3) @(posedge clk);
        cmp("pdown hold", 32'h1, pin_hold);
        cmp("pdown osc", 32'h0, clk_en.osc);
        cmp("pdown rtc", 32'h1, clk_en.rtc);
        cmp("pdown periph_en", 32'h0, periph_en);
        ext_pin <= 9'h001;
        cap_pin <= 4'h1;
        @(posedge clk);
        ext_pin <= '0;
        cap_pin <= '0;
        repeat (5) @(posedge clk);
        cmp("pdown stays", 32'(PMC_PDOWN), mode);
        ext_pin <= 9'h010;
        @(posedge clk);
        ext_pin <= '0;
        wait_cpu(120);
        rdchk(`PMC_OFS_STATUS, 32'h011);
        rdchk(`PMC_OFS_PERIPH, 32'h00A5);
        rdchk(`PMC_OFS_MODE, 32'h0);
        // Reset ends idle and restores the quarter divider
        apb(1'b1, `PMC_OFS_MODE, 32'h1);
        repeat (3) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        cmp("reset cpu", 32'h1, clk_en.cpu);
        rdchk(`PMC_OFS_DIV, 32'h0);
        repeat (12) @(posedge clk);
        end_of_test();
    end
endmodule
